// [design/mce_regs.v]
// Local design decision: the AHB-Lite register port.
`timescale 1ns/10ps
`include "mce_defines.vh"

module mce_regs #(
    parameter ADDR_W = 8
)
(
    input wire clk,
    input wire sys_rst,
    input wire hsel,
    input wire [ADDR_W-1:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire core_data_ready,
    input wire step_detect,
    input wire hub_data_ready,
    input wire irq_pin_two,
    input wire freefall_event,
    input wire sleep_event,
    input wire wake_event,
    input wire [2:0] wake_axis,
    input wire knock_event,
    input wire knock_single,
    input wire knock_double,
    input wire knock_negative,
    input wire [2:0] knock_axis,
    output reg [2:0] gyro_axis_en,
    output reg embedded_features_on,
    output reg accel_filters_on,
    output reg step_counter_on,
    output reg tilt_on,
    output reg step_counter_clear,
    output reg sig_motion_on,
    output reg hub_master_on,
    output reg hub_trigger,
    output reg hard_iron_on,
    output reg soft_iron_on,
    output reg aux_pullup_on,
    output reg pass_through_on,
    output reg irq_pin_one,
    output reg queue_write_strobe
);

    reg [7:0] axis_ctrl_reg;
    reg [7:0] hub_cfg_reg;
    reg [7:0] aux_ctrl_reg;
    reg freefall_flag_reg;
    reg sleep_flag_reg;
    reg wake_flag_reg;
    reg [2:0] wake_axis_reg;
    reg knock_flag_reg;
    reg knock_single_reg;
    reg knock_double_reg;
    reg knock_sign_reg;
    reg [2:0] knock_axis_reg;
    reg wr_pend_reg;
    reg [ADDR_W-3:0] wr_idx_reg;
    reg [7:0] rd_byte;
    reg [7:0] wake_view;
    reg [7:0] knock_view;
    reg [31:0] hrdata_next;

    wire func_on;
    wire rounding_on;
    wire addr_ok;
    wire take;
    wire rd_take;
    wire [ADDR_W-3:0] idx;
    wire rd_wake;
    wire rd_knock;
    wire [7:0] wdat;

    assign func_on = axis_ctrl_reg[`MCE_B_FUNC_ON];
    assign rounding_on = aux_ctrl_reg[`MCE_B_ROUNDING];
    // Zero-wait slave; every access completes with OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_ok = (haddr[1:0] == 2'b00);
    assign take = hsel & hready & htrans[1] & addr_ok;
    assign rd_take = take & ~hwrite;
    assign idx = haddr[ADDR_W-1:2];
    assign rd_wake = rd_take & (idx == `MCE_IDX_WAKE_SRC);
    assign rd_knock = rd_take & (idx == `MCE_IDX_KNOCK_SRC);
    assign wdat = hwdata[7:0];

    // Rounding off: wake flags show live detector levels
    always @*
    begin
        if (rounding_on) // [R23]
        begin
            wake_view = {2'b00, freefall_flag_reg, sleep_flag_reg, wake_flag_reg, wake_axis_reg};
        end
        else
        begin
            wake_view = {2'b00, freefall_event, sleep_event, wake_event, wake_axis};
        end
        knock_view = {1'b0, knock_flag_reg, knock_single_reg, knock_double_reg,
                      knock_sign_reg, knock_axis_reg};
    end

    always @*
    begin
        case (idx)
            `MCE_IDX_AXIS_CTRL: rd_byte = axis_ctrl_reg;
            `MCE_IDX_HUB_CFG: rd_byte = hub_cfg_reg;
            `MCE_IDX_WAKE_SRC: rd_byte = wake_view;
            `MCE_IDX_KNOCK_SRC: rd_byte = knock_view;
            `MCE_IDX_AUX_CTRL: rd_byte = aux_ctrl_reg;
            default: rd_byte = 8'h00;
        endcase
        hrdata_next = rd_take ? {24'h000000, rd_byte} : 32'h00000000;
    end

    // Read data is taken in the address phase and stands in the data phase
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            hrdata <= 32'h00000000;
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= {(ADDR_W-2){1'b0}};
        end
        else
        begin
            hrdata <= hrdata_next;
            wr_pend_reg <= take & hwrite;
            wr_idx_reg <= idx;
        end
    end

    // Reserved bits are forced to zero whatever the host writes
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            axis_ctrl_reg <= `MCE_AXIS_CTRL_RST; // [R1]
            hub_cfg_reg <= `MCE_HUB_CFG_RST;
            aux_ctrl_reg <= `MCE_AUX_CTRL_RST;
            step_counter_clear <= 1'b0;
        end
        else
        begin
            step_counter_clear <= 1'b0;
            if (wr_pend_reg)
            begin
                case (wr_idx_reg)
                    `MCE_IDX_AXIS_CTRL:
                    begin
                        axis_ctrl_reg <= wdat & `MCE_AXIS_CTRL_MASK; // [R5]
                        step_counter_clear <= wdat[`MCE_B_STEP_CLR]; // [R3]
                    end
                    `MCE_IDX_HUB_CFG: hub_cfg_reg <= wdat & `MCE_HUB_CFG_MASK; // [R5]
                    `MCE_IDX_AUX_CTRL: aux_ctrl_reg <= wdat & `MCE_AUX_CTRL_MASK;
                    default: axis_ctrl_reg <= axis_ctrl_reg; // [R25]
                endcase
            end
        end
    end

    // Latched wake flags: an event in the clearing read wins over the clear
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            freefall_flag_reg <= 1'b0;
            sleep_flag_reg <= 1'b0;
            wake_flag_reg <= 1'b0;
            wake_axis_reg <= 3'h0;
        end
        else if (rd_wake & rounding_on)
        begin
            freefall_flag_reg <= freefall_event; // [R14]
            sleep_flag_reg <= sleep_event; // [R15]
            wake_flag_reg <= wake_event; // [R16]
            wake_axis_reg <= wake_event ? wake_axis : 3'h0; // [R17]
        end
        else
        begin
            freefall_flag_reg <= freefall_flag_reg | freefall_event; // [R14]
            sleep_flag_reg <= sleep_flag_reg | sleep_event; // [R15]
            wake_flag_reg <= wake_flag_reg | wake_event; // [R16]
            wake_axis_reg <= wake_axis_reg | (wake_event ? wake_axis : 3'h0); // [R17]
        end
    end

    // Tap flags hold until the source is read; a new tap replaces the detail
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            knock_flag_reg <= 1'b0;
            knock_single_reg <= 1'b0;
            knock_double_reg <= 1'b0;
            knock_sign_reg <= 1'b0;
            knock_axis_reg <= 3'h0;
        end
        else if (knock_event)
        begin
            knock_flag_reg <= 1'b1; // [R18]
            knock_single_reg <= knock_single; // [R19]
            knock_double_reg <= knock_double; // [R20]
            knock_sign_reg <= knock_negative; // [R21]
            knock_axis_reg <= knock_axis; // [R22]
        end
        else if (rd_knock)
        begin
            knock_flag_reg <= 1'b0;
            knock_single_reg <= 1'b0;
            knock_double_reg <= 1'b0;
            knock_sign_reg <= 1'b0;
            knock_axis_reg <= 3'h0;
        end
    end

    // Function outputs, registered from the control bits
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            gyro_axis_en <= 3'h7;
            embedded_features_on <= 1'b0;
            accel_filters_on <= 1'b0;
            step_counter_on <= 1'b0;
            tilt_on <= 1'b0;
            sig_motion_on <= 1'b0;
            hub_master_on <= 1'b0;
            hub_trigger <= 1'b0;
            hard_iron_on <= 1'b0;
            soft_iron_on <= 1'b0;
            aux_pullup_on <= 1'b0;
            pass_through_on <= 1'b0;
            irq_pin_one <= 1'b0;
            queue_write_strobe <= 1'b0;
        end
        else
        begin
            gyro_axis_en <= {axis_ctrl_reg[`MCE_B_GYRO_Z], axis_ctrl_reg[`MCE_B_GYRO_Y],
                             axis_ctrl_reg[`MCE_B_GYRO_X]}; // [R1]
            embedded_features_on <= func_on; // [R2]
            accel_filters_on <= func_on; // [R2]
            step_counter_on <= func_on; // [R2]
            tilt_on <= func_on; // [R2]
            sig_motion_on <= func_on & axis_ctrl_reg[`MCE_B_SIG_MOTION]; // [R4]
            hub_master_on <= func_on & hub_cfg_reg[`MCE_B_MASTER_ON]; // [R13]
            if (hub_cfg_reg[`MCE_B_TRIG_SEL]) // [R9]
                hub_trigger <= func_on & hub_cfg_reg[`MCE_B_MASTER_ON] & irq_pin_two;
            else
                hub_trigger <= func_on & hub_cfg_reg[`MCE_B_MASTER_ON] & core_data_ready;
            hard_iron_on <= func_on & hub_cfg_reg[`MCE_B_HARD_IRON]; // [R12]
            soft_iron_on <= func_on & hub_cfg_reg[`MCE_B_HARD_IRON]
                            & aux_ctrl_reg[`MCE_B_SOFT_IRON]; // [R24]
            aux_pullup_on <= hub_cfg_reg[`MCE_B_PULL_UP]; // [R10]
            pass_through_on <= hub_cfg_reg[`MCE_B_PASS_THRU]; // [R11]
            irq_pin_one <= hub_cfg_reg[`MCE_B_READY_IRQ1] & hub_data_ready; // [R6]
            if (hub_cfg_reg[`MCE_B_VALID_SEL]) // [R7]
                queue_write_strobe <= hub_data_ready;
            else if (aux_ctrl_reg[`MCE_B_STEP_TRIG]) // [R8]
                queue_write_strobe <= step_detect;
            else
                queue_write_strobe <= core_data_ready; // [R8]
        end
    end

endmodule // mce_regs

// [pkg/mce_defines.vh]
// Behaviour
// [R1] Gyro Z, Y, X output enables reset to 1; 0 disables that axis output.
// [R2] Embedded-function enable, reset 0, gates all embedded functions and accel filters.
// [R3] Writing 1 to the step counter clear bit clears the step counter.
// [R4] Significant-motion enable, reset 0, turns significant motion detection on or off.
// [R5] Host writes 0 into every reserved bit of these registers.
// [R6] Hub-ready routing bit, reset 0, puts hub data-ready onto interrupt pin one.
// [R7] FIFO data-valid select 0: core ready or step; 1: hub data-ready.
// [R8] With select 0, step trigger select 0 uses core ready, else step detection.
// [R9] Hub trigger select 0: core data-ready; 1: external signal on pin two.
// [R10] Pull-up bit, reset 0, enables internal pull-up on auxiliary bus lines.
// [R11] Pass-through bit, reset 0, connects primary bus through to auxiliary bus.
// [R12] Hard-iron enable, reset 0, turns on magnetometer hard-iron correction.
// [R13] Hub master enable, reset 0, activates the hub bus master engine.
// [R14] Wake source free-fall flag resets 0, reads 1 after free-fall detected.
// [R15] Wake source sleep flag resets 0, reads 1 after sleep event.
// [R16] Wake source wake flag resets 0, reads 1 after wake event on any axis.
// [R17] Per-axis wake flags X, Y, Z reset 0, report axis of wake event.
// [R18] Tap source tap flag resets 0, reads 1 after any tap event.
// [R19] Single-tap flag resets 0, reads 1 after a single tap.
// [R20] Double-tap flag resets 0, reads 1 after a double tap.
// [R21] Tap sign resets 0; 0 positive, 1 negative acceleration.
// [R22] Per-axis tap flags X, Y, Z reset 0, report axis of tap event.
// [R23] Rounding enable set makes wake source reads take part in rounding.
// [R24] Soft-iron enable acts only while hard-iron enable is 1.
// [R25] Source registers are read-only; writes leave every flag unchanged.
`ifndef MCE_DEFINES_VH
`define MCE_DEFINES_VH

`define MCE_IDX_AXIS_CTRL 6'h19
`define MCE_IDX_HUB_CFG 6'h1A
`define MCE_IDX_WAKE_SRC 6'h1B
`define MCE_IDX_KNOCK_SRC 6'h1C
`define MCE_IDX_AUX_CTRL 6'h20

`define MCE_AXIS_CTRL_RST 8'h38
`define MCE_AXIS_CTRL_MASK 8'h3F
`define MCE_HUB_CFG_RST 8'h00
`define MCE_HUB_CFG_MASK 8'hDF
`define MCE_AUX_CTRL_RST 8'h00
`define MCE_AUX_CTRL_MASK 8'h07

`define MCE_B_SIG_MOTION 0
`define MCE_B_STEP_CLR 1
`define MCE_B_FUNC_ON 2
`define MCE_B_GYRO_X 3
`define MCE_B_GYRO_Y 4
`define MCE_B_GYRO_Z 5

`define MCE_B_MASTER_ON 0
`define MCE_B_HARD_IRON 1
`define MCE_B_PASS_THRU 2
`define MCE_B_PULL_UP 3
`define MCE_B_TRIG_SEL 4
`define MCE_B_VALID_SEL 6
`define MCE_B_READY_IRQ1 7

`define MCE_B_ROUNDING 0
`define MCE_B_SOFT_IRON 1
`define MCE_B_STEP_TRIG 2

`endif

// [testbench/mce_host.sv]
`timescale 1ns/10ps
module mce_host (
    input wire clk,
    input wire hready,
    output logic hsel,
    output logic [7:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output wire [2:0] hsize,
    output logic [31:0] hwdata,
    output logic rdv
);
    initial {hsel, haddr, htrans, hwrite, hwdata, rdv} = '0;
    assign hsize = 3'h2;
    // Single word transfers; no latency assumed, waits on hready
    task xfer(input [7:0] a, input w, input [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        rdv <= !w;
        if (w)
            hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rdv <= 1'b0;
    endtask
endmodule // mce_host

// [testbench/mce_regs_properties.sv]
`timescale 1ns/10ps
module mce_regs_props (
    input wire clk,
    input wire sys_rst,
    input wire [31:0] hwdata,
    input wire core_data_ready,
    input wire step_detect,
    input wire hub_data_ready,
    input wire irq_pin_two,
    input wire [2:0] gyro_axis_en,
    input wire embedded_features_on,
    input wire accel_filters_on,
    input wire step_counter_on,
    input wire tilt_on,
    input wire step_counter_clear,
    input wire sig_motion_on,
    input wire hub_master_on,
    input wire hub_trigger,
    input wire hard_iron_on,
    input wire soft_iron_on,
    input wire irq_pin_one,
    input wire queue_write_strobe
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_rst; $fell(sys_rst) |-> gyro_axis_en == 3'h7 && !embedded_features_on; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_func; accel_filters_on == embedded_features_on && tilt_on == embedded_features_on
        && step_counter_on == embedded_features_on; endproperty
    a_func: assert property (p_func) else $error("function gates differ");
    property p_gate; sig_motion_on || hub_master_on || hard_iron_on |-> embedded_features_on;
    endproperty
    a_gate: assert property (p_gate) else $error("function on while gated");
    property p_soft; soft_iron_on |-> hard_iron_on; endproperty
    a_soft: assert property (p_soft) else $error("soft iron without hard iron");
    property p_trig; hub_trigger |-> hub_master_on && $past(irq_pin_two || core_data_ready);
    endproperty
    a_trig: assert property (p_trig) else $error("hub trigger without cause");
    property p_irq; irq_pin_one |-> $past(hub_data_ready); endproperty
    a_irq: assert property (p_irq) else $error("irq one without hub ready");
    property p_fifo; queue_write_strobe |-> $past(hub_data_ready || step_detect || core_data_ready);
    endproperty
    a_fifo: assert property (p_fifo) else $error("queue strobe without source");
    property p_clr; step_counter_clear |-> $past(hwdata[1]) || $past(hwdata[1], 2); endproperty
    a_clr: assert property (p_clr) else $error("step clear without write");
endmodule // mce_regs_props
bind mce_regs mce_regs_props chk (.clk, .sys_rst, .hwdata, .core_data_ready, .step_detect,
    .hub_data_ready, .irq_pin_two, .gyro_axis_en, .embedded_features_on, .accel_filters_on,
    .step_counter_on, .tilt_on, .step_counter_clear, .sig_motion_on, .hub_master_on,
    .hub_trigger, .hard_iron_on, .soft_iron_on, .irq_pin_one, .queue_write_strobe);

// [testbench/test_motion_ctrl_event_status_regs.sv]
`timescale 1ns/10ps
module test_motion_ctrl_event_status_regs;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [16:0] s = 17'h0;
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [31:0] exp_q[$];
    logic [7:0] a, b, c, k;
    logic [5:0] w = 6'h0;
    wire core_data_ready = s[16], step_detect = s[15], hub_data_ready = s[14];
    wire irq_pin_two = s[13], freefall_event = s[12], sleep_event = s[11], wake_event = s[10];
    wire knock_event = s[6], knock_single = s[5], knock_double = s[4], knock_negative = s[3];
    wire [2:0] wake_axis = s[9:7], knock_axis = s[2:0];
    wire [31:0] hrdata, hwdata;
    wire [7:0] haddr;
    wire [2:0] gyro_axis_en, hsize;
    wire [1:0] htrans;
    wire hreadyout, hresp, hsel, hwrite, rdv, embedded_features_on, accel_filters_on;
    wire step_counter_on, tilt_on, step_counter_clear, sig_motion_on, hub_master_on;
    wire hub_trigger, hard_iron_on, soft_iron_on, aux_pullup_on, pass_through_on;
    wire irq_pin_one, queue_write_strobe;
    wire hready = hreadyout;
    mce_regs dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .core_data_ready(core_data_ready),
        .step_detect(step_detect),
        .hub_data_ready(hub_data_ready),
        .irq_pin_two(irq_pin_two),
        .freefall_event(freefall_event),
        .sleep_event(sleep_event),
        .wake_event(wake_event),
        .wake_axis(wake_axis),
        .knock_event(knock_event),
        .knock_single(knock_single),
        .knock_double(knock_double),
        .knock_negative(knock_negative),
        .knock_axis(knock_axis),
        .gyro_axis_en(gyro_axis_en),
        .embedded_features_on(embedded_features_on),
        .accel_filters_on(accel_filters_on),
        .step_counter_on(step_counter_on),
        .tilt_on(tilt_on),
        .step_counter_clear(step_counter_clear),
        .sig_motion_on(sig_motion_on),
        .hub_master_on(hub_master_on),
        .hub_trigger(hub_trigger),
        .hard_iron_on(hard_iron_on),
        .soft_iron_on(soft_iron_on),
        .aux_pullup_on(aux_pullup_on),
        .pass_through_on(pass_through_on),
        .irq_pin_one(irq_pin_one),
        .queue_write_strobe(queue_write_strobe)
    );
    mce_host host (
        .clk(clk),
        .hready(hready),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .rdv(rdv)
    );
    always #5 clk = ~clk;
    task chk(input string n, input logic [31:0] v, input logic [31:0] e);
        n_checks++;
        if (v !== e)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, v);
        end
    endtask
    task summarize;
        if (miscompares == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task wr(input [7:0] ad, input [7:0] d);
        host.xfer(ad, 1'b1, {24'h0, d});
    endtask
    task rd(input [7:0] ad, input [7:0] e);
        exp_q.push_back({24'h0, e});
        host.xfer(ad, 1'b0, 32'h0);
    endtask
    // Registered outputs lag their cause by one edge
    task settle;
        @(posedge clk);
        @(posedge clk);
        @(negedge clk);
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (rdv === 1'b1)
        begin
            chk("hrdata", hrdata, exp_q.pop_front());
            chk("hresp", hresp, 32'h0);
        end
        if (cyc == 20000)
        begin
            miscompares++;
            summarize;
        end
    end
    initial
    begin
        void'($urandom(32'h15E3));
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        rd(8'h64, 8'h38);
        rd(8'h68, 8'h00);
        rd(8'h6C, 8'h00);
        rd(8'h70, 8'h00);
        wr(8'h90, 8'hFF);
        rd(8'h90, 8'h00);
        for (int i = 0; i < 12; i++)
        begin
            a = 8'($urandom) & 8'h3F;
            b = 8'($urandom) & 8'hDF;
            c = 8'($urandom) & 8'h07;
            wr(8'h64, a);
            #1 chk("stepclr", step_counter_clear, a[1]);
            wr(8'h68, b);
            wr(8'h80, c);
            rd(8'h64, a);
            rd(8'h68, b);
            @(posedge clk) s <= {4'($urandom), 13'h0};
            settle;
            chk("gyro", gyro_axis_en, a[5:3]);
            chk("func", embedded_features_on, a[2]);
            chk("gates", {accel_filters_on, step_counter_on, tilt_on, step_counter_clear},
                {{3{a[2]}}, 1'b0});
            chk("sig", sig_motion_on, a[2] & a[0]);
            chk("master", hub_master_on, a[2] & b[0]);
            chk("iron", {hard_iron_on, soft_iron_on}, {2{a[2] & b[1]}} & {1'b1, c[1]});
            chk("aux", {aux_pullup_on, pass_through_on}, b[3:2]);
            chk("irq1", irq_pin_one, s[14] & b[7]);
            chk("trig", hub_trigger, a[2] & b[0] & (b[4] ? s[13] : s[16]));
            chk("queue", queue_write_strobe, b[6] ? s[14] : (c[2] ? s[15] : s[16]));
        end
        wr(8'h80, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk) s <= {4'h0, 6'($urandom), 7'h0};
            wr(8'h6C, 8'h3F);
            rd(8'h6C, {2'b00, s[12:7]});
            // Latched flags keep gathering while rounding is off
            w = w | {s[12:10], s[10] ? s[9:7] : 3'h0};
        end
        @(posedge clk) s <= 17'h0;
        wr(8'h80, 8'h01);
        rd(8'h6C, {2'b00, w});
        @(posedge clk) s <= 17'h00600;
        @(posedge clk) s <= 17'h0;
        rd(8'h6C, 8'h0C);
        rd(8'h6C, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            k = 8'($urandom);
            @(posedge clk) s <= {10'h0, 1'b1, k[5:0]};
            @(posedge clk) s <= 17'h0;
            wr(8'h70, 8'h00);
            rd(8'h70, {2'b01, k[5:0]});
            rd(8'h70, 8'h00);
        end
        summarize;
    end
endmodule // test_motion_ctrl_event_status_regs
